// ### core/flag_unit_pkg.sv
package flag_unit_pkg;

    // Flag word layout
    localparam int          FLAG_W      = 16;
    localparam int          CF_BIT      = 0;
    localparam int          IF_BIT      = 9;
    localparam int          DF_BIT      = 10;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;

    // Opcodes of the instruction stream
    localparam logic [7:0] OP_CLR_CARRY = 8'hf8;
    localparam logic [7:0] OP_CLR_DIR   = 8'hfc;
    localparam logic [7:0] OP_CLR_IRQEN = 8'hfa;
    localparam logic [7:0] OP_SET_IRQEN = 8'h10;
    localparam logic [7:0] OP_SET_CARRY = 8'h11;
    localparam logic [7:0] OP_RETURN    = 8'h12;
    localparam logic [7:0] OP_ROT_LEFT  = 8'h13;
    localparam logic [7:0] OP_ROT_RIGHT = 8'h14;
    localparam logic [7:0] OP_TRAP_CALL = 8'h15;
    localparam logic [7:0] OP_STRING    = 8'h16;
    localparam logic [7:0] OP_SET_DIR   = 8'h17;

    // Register byte offsets
    localparam logic [7:0] OFF_FLAGS   = 8'h00;
    localparam logic [7:0] OFF_SRC     = 8'h04;
    localparam logic [7:0] OFF_DST     = 8'h08;
    localparam logic [7:0] OFF_OPERAND = 8'h0c;
    localparam logic [7:0] OFF_MASK    = 8'h10;
    localparam logic [7:0] OFF_IN_SERVICE_BITS  = 8'h14;
    localparam logic [7:0] OFF_EOI     = 8'h18;

    localparam logic [15:0] EOI_NONSPECIFIC = 16'h8000;

    // Interrupt sources and handler stack
    localparam int         IRQ_N       = 4;
    localparam logic [3:0] MASK_RESET  = 4'hf;
    localparam int         STACK_AW    = 3;
    localparam int         STACK_DEPTH = 8;
    localparam logic [2:0] VEC_NMI     = 3'h4;
    localparam logic [2:0] VEC_TRAP    = 3'h5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_ENTRY,
        ST_POP
    } exec_state_e;

endpackage : flag_unit_pkg

// ### core/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end

endmodule : sync_two_stage

// ### core/flag_stack_mem.sv
`timescale 1ns/1ps
module flag_stack_mem (
    input  wire logic                            clk,
    input  wire logic                            wrEn,
    input  wire logic [flag_unit_pkg::STACK_AW-1:0] wrAddr,
    input  wire logic [15:0]                     wrData,
    input  wire logic [flag_unit_pkg::STACK_AW-1:0] rdAddr,
    output logic      [15:0]                     rdData
);

    logic [15:0] mem [flag_unit_pkg::STACK_DEPTH];

    // Saved flag words, read data registered
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule : flag_stack_mem

// ### core/flag_clear_instruction_unit.sv
`timescale 1ns/1ps
module flag_clear_instruction_unit (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        instrValid,
    input  wire logic [7:0]  instrOpcode,
    output logic             instrReady,
    output logic             instrDone,
    input  wire logic [3:0]  irqPin,
    input  wire logic        nmiPin,
    output logic             intTaken,
    output logic      [2:0]  intVector,
    output logic      [15:0] flagsOut,
    output logic      [15:0] srcIndexOut,
    output logic      [15:0] dstIndexOut
);

    flag_unit_pkg::exec_state_e state_reg;
    flag_unit_pkg::exec_state_e state_next;
    logic [15:0] flags_reg;
    logic [15:0] srcIndex_reg;
    logic [15:0] dstIndex_reg;
    logic [15:0] operand_reg;
    logic [7:0]  op_reg;
    logic [3:0]  mask_reg;
    logic [3:0]  inService_reg;
    logic [2:0]  sp_reg;
    logic [2:0]  intSrc_reg;
    logic        stiShadow_reg;
    logic        nmiPend_reg;
    logic        nmiLast_reg;
    logic [3:0]  irqSync;
    logic        nmiSync;
    logic [15:0] stackRd;
    logic        accept;
    logic        isExec;
    logic        ifAfter;
    logic        maskOk;
    logic        boundary;
    logic        goEntry;
    logic        takeMask;
    logic [3:0]  irqCand;
    logic [1:0]  irqPick;
    logic        apbAccess;
    logic        apbWr;
    logic        eoiWr;
    logic [2:0]  spDown;

    // Pins cross into the clock domain
    sync_two_stage #(.W(4)) u_irq_sync (
        .clk   (clk),
        .reset (reset),
        .din   (irqPin),
        .dout  (irqSync)
    );

    sync_two_stage #(.W(1)) u_nmi_sync (
        .clk   (clk),
        .reset (reset),
        .din   (nmiPin),
        .dout  (nmiSync)
    );

    // Pointer wraps; nesting deeper than the stack overwrites
    assign spDown = sp_reg - 3'h1;

    flag_stack_mem u_stack (
        .clk    (clk),
        .wrEn   (state_reg == flag_unit_pkg::ST_ENTRY),
        .wrAddr (sp_reg),
        .wrData (flags_reg),
        .rdAddr (spDown),
        .rdData (stackRd)
    );

    // Recognition at instruction boundaries
    assign accept   = state_reg == flag_unit_pkg::ST_IDLE
                      && instrReady && instrValid;
    assign isExec   = state_reg == flag_unit_pkg::ST_EXEC;
    assign ifAfter  = (isExec && op_reg == flag_unit_pkg::OP_CLR_IRQEN)
                      ? 1'b0 : flags_reg[flag_unit_pkg::IF_BIT];
    assign irqCand  = irqSync & ~mask_reg & ~inService_reg;
    // Shadow lifts only once the following instruction has run
    assign maskOk   = isExec
                      ? (ifAfter && op_reg != flag_unit_pkg::OP_SET_IRQEN)
                      : (flags_reg[flag_unit_pkg::IF_BIT]
                         && !stiShadow_reg);
    assign boundary = (state_reg == flag_unit_pkg::ST_IDLE && !accept)
                      || (isExec && op_reg != flag_unit_pkg::OP_RETURN
                          && op_reg != flag_unit_pkg::OP_TRAP_CALL);
    assign takeMask = boundary && !nmiPend_reg && maskOk && |irqCand;
    assign goEntry  = boundary && (nmiPend_reg || takeMask);

    // Lowest numbered source wins
    always_comb begin
        irqPick = 2'h0;
        for (int i = flag_unit_pkg::IRQ_N - 1; i >= 0; i--) begin
            if (irqCand[i]) begin
                irqPick = 2'(i);
            end
        end
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            flag_unit_pkg::ST_IDLE: begin
                if (accept) begin
                    state_next = flag_unit_pkg::ST_EXEC;
                end else if (goEntry) begin
                    state_next = flag_unit_pkg::ST_ENTRY;
                end
            end
            flag_unit_pkg::ST_EXEC: begin
                if (op_reg == flag_unit_pkg::OP_TRAP_CALL) begin
                    state_next = flag_unit_pkg::ST_ENTRY;
                end else if (op_reg == flag_unit_pkg::OP_RETURN) begin
                    state_next = flag_unit_pkg::ST_POP;
                end else if (goEntry) begin
                    state_next = flag_unit_pkg::ST_ENTRY;
                end else begin
                    state_next = flag_unit_pkg::ST_IDLE;
                end
            end
            flag_unit_pkg::ST_ENTRY: state_next = flag_unit_pkg::ST_IDLE;
            flag_unit_pkg::ST_POP:   state_next = flag_unit_pkg::ST_IDLE;
        endcase
    end

    // State, opcode latch and instruction handshake
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= flag_unit_pkg::ST_IDLE;
            op_reg     <= 8'h00;
            instrReady <= 1'b0;
            instrDone  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            instrReady <= state_next == flag_unit_pkg::ST_IDLE;
            instrDone  <= (isExec && op_reg != flag_unit_pkg::OP_RETURN)
                          || state_reg == flag_unit_pkg::ST_POP;
            if (accept) begin
                op_reg <= instrOpcode;
            end
        end
    end

    // Flag word: execution beats a register write
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= flag_unit_pkg::FLAGS_RESET;
        end else if (isExec) begin
            unique case (op_reg)
                flag_unit_pkg::OP_CLR_CARRY:
                    flags_reg[flag_unit_pkg::CF_BIT] <= 1'b0;
                flag_unit_pkg::OP_SET_CARRY:
                    flags_reg[flag_unit_pkg::CF_BIT] <= 1'b1;
                flag_unit_pkg::OP_CLR_DIR:
                    flags_reg[flag_unit_pkg::DF_BIT] <= 1'b0;
                flag_unit_pkg::OP_SET_DIR:
                    flags_reg[flag_unit_pkg::DF_BIT] <= 1'b1;
                flag_unit_pkg::OP_CLR_IRQEN:
                    flags_reg[flag_unit_pkg::IF_BIT] <= 1'b0;
                flag_unit_pkg::OP_SET_IRQEN:
                    flags_reg[flag_unit_pkg::IF_BIT] <= 1'b1;
                flag_unit_pkg::OP_ROT_LEFT:
                    flags_reg[flag_unit_pkg::CF_BIT] <= operand_reg[15];
                flag_unit_pkg::OP_ROT_RIGHT:
                    flags_reg[flag_unit_pkg::CF_BIT] <= operand_reg[0];
                default: ; // Others leave the flags alone
            endcase
        end else if (state_reg == flag_unit_pkg::ST_ENTRY) begin
            flags_reg[flag_unit_pkg::IF_BIT] <= 1'b0;
        end else if (state_reg == flag_unit_pkg::ST_POP) begin
            flags_reg <= stackRd;
        end else if (apbWr && paddr == flag_unit_pkg::OFF_FLAGS) begin
            flags_reg <= pwdata[15:0];
        end
    end

    // Rotate operand through carry
    always_ff @(posedge clk) begin
        if (reset) begin
            operand_reg <= 16'h0000;
        end else if (isExec && op_reg == flag_unit_pkg::OP_ROT_LEFT) begin
            operand_reg <= {operand_reg[14:0],
                            flags_reg[flag_unit_pkg::CF_BIT]};
        end else if (isExec && op_reg == flag_unit_pkg::OP_ROT_RIGHT) begin
            operand_reg <= {flags_reg[flag_unit_pkg::CF_BIT],
                            operand_reg[15:1]};
        end else if (apbWr && paddr == flag_unit_pkg::OFF_OPERAND) begin
            operand_reg <= pwdata[15:0];
        end
    end

    // String step moves both indexes every component
    always_ff @(posedge clk) begin
        if (reset) begin
            srcIndex_reg <= 16'h0000;
            dstIndex_reg <= 16'h0000;
        end else if (isExec && op_reg == flag_unit_pkg::OP_STRING) begin
            if (!flags_reg[flag_unit_pkg::DF_BIT]) begin
                srcIndex_reg <= srcIndex_reg + 16'h0001;
                dstIndex_reg <= dstIndex_reg + 16'h0001;
            end else begin
                srcIndex_reg <= srcIndex_reg - 16'h0001;
                dstIndex_reg <= dstIndex_reg - 16'h0001;
            end
        end else if (apbWr) begin
            if (paddr == flag_unit_pkg::OFF_SRC) begin
                srcIndex_reg <= pwdata[15:0];
            end
            if (paddr == flag_unit_pkg::OFF_DST) begin
                dstIndex_reg <= pwdata[15:0];
            end
        end
    end

    // Enable shadow and nonmaskable edge latch
    always_ff @(posedge clk) begin
        if (reset) begin
            stiShadow_reg <= 1'b0;
            nmiPend_reg   <= 1'b0;
            nmiLast_reg   <= 1'b0;
        end else begin
            nmiLast_reg <= nmiSync;
            if (isExec) begin
                stiShadow_reg <= op_reg == flag_unit_pkg::OP_SET_IRQEN;
            end
            // A new edge wins over the take
            nmiPend_reg <= (nmiSync && !nmiLast_reg)
                           || (nmiPend_reg
                               && !(boundary && state_next
                                    == flag_unit_pkg::ST_ENTRY));
        end
    end

    // Handler entry pushes flags, return pops them
    always_ff @(posedge clk) begin
        if (reset) begin
            sp_reg     <= 3'h0;
            intSrc_reg <= 3'h0;
            intTaken   <= 1'b0;
            intVector  <= 3'h0;
        end else begin
            intTaken <= state_reg == flag_unit_pkg::ST_ENTRY;
            if (state_reg == flag_unit_pkg::ST_ENTRY) begin
                sp_reg    <= sp_reg + 3'h1;
                intVector <= intSrc_reg;
            end else if (state_reg == flag_unit_pkg::ST_POP) begin
                sp_reg <= spDown;
            end
            if (isExec && op_reg == flag_unit_pkg::OP_TRAP_CALL) begin
                intSrc_reg <= flag_unit_pkg::VEC_TRAP;
            end else if (goEntry) begin
                intSrc_reg <= nmiPend_reg ? flag_unit_pkg::VEC_NMI
                                          : {1'b0, irqPick};
            end
        end
    end

    // In-service bits; a new entry wins over end-of-service
    assign eoiWr = apbWr && paddr == flag_unit_pkg::OFF_EOI
                   && pwdata[15:0] == flag_unit_pkg::EOI_NONSPECIFIC;

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_reg      <= flag_unit_pkg::MASK_RESET;
            inService_reg <= 4'h0;
        end else begin
            inService_reg <= (eoiWr ? 4'h0 : inService_reg)
                | ((state_reg == flag_unit_pkg::ST_ENTRY && !intSrc_reg[2])
                   ? 4'(4'h1 << intSrc_reg[1:0]) : 4'h0);
            if (apbWr && paddr == flag_unit_pkg::OFF_MASK) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    // Slave answers one cycle into the access phase
    assign apbAccess = psel && penable;
    assign apbWr     = apbAccess && pready && pwrite;

    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apbAccess && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apbAccess && !pready) begin
                unique case (paddr)
                    flag_unit_pkg::OFF_FLAGS:   prdata <= {16'h0, flags_reg};
                    flag_unit_pkg::OFF_SRC:     prdata <= {16'h0, srcIndex_reg};
                    flag_unit_pkg::OFF_DST:     prdata <= {16'h0, dstIndex_reg};
                    flag_unit_pkg::OFF_OPERAND: prdata <= {16'h0, operand_reg};
                    flag_unit_pkg::OFF_MASK:    prdata <= {28'h0, mask_reg};
                    flag_unit_pkg::OFF_IN_SERVICE_BITS:
                        prdata <= {28'h0, inService_reg};
                    flag_unit_pkg::OFF_EOI:     prdata <= 32'h0000_0000;
                    default:                    pslverr <= 1'b1;
                endcase
            end
        end
    end

    assign flagsOut    = flags_reg;
    assign srcIndexOut = srcIndex_reg;
    assign dstIndexOut = dstIndex_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence returnIssue;
        isExec && op_reg == flag_unit_pkg::OP_RETURN;
    endsequence

    a_dir_clear_done: assert property (isExec
        && op_reg == flag_unit_pkg::OP_CLR_DIR
        |=> !flags_reg[10] && instrDone
            && (instrReady || state_reg == flag_unit_pkg::ST_ENTRY))
        else $error("direction clear not done in two cycles");
    a_string_steps_up: assert property (isExec
        && op_reg == flag_unit_pkg::OP_STRING && !flags_reg[10]
        |=> srcIndex_reg == $past(srcIndex_reg) + 16'h0001
            && dstIndex_reg == $past(dstIndex_reg) + 16'h0001)
        else $error("string step did not increment");
    a_string_always_moves: assert property (isExec
        && op_reg == flag_unit_pkg::OP_STRING
        |=> srcIndex_reg != $past(srcIndex_reg))
        else $error("string step left index unchanged");
    a_irqen_clear_done: assert property (isExec
        && op_reg == flag_unit_pkg::OP_CLR_IRQEN
        |=> !flags_reg[9] && flags_reg[10] == $past(flags_reg[10]))
        else $error("enable clear wrong");
    a_masked_ignored: assert property (!flags_reg[9]
        |-> !takeMask)
        else $error("maskable taken with enable clear");
    a_shadow_holds: assert property (state_reg
        == flag_unit_pkg::ST_IDLE && stiShadow_reg |-> !takeMask)
        else $error("maskable taken inside shadow");
    a_trap_taken: assert property (isExec
        && op_reg == flag_unit_pkg::OP_TRAP_CALL
        |=> state_reg == flag_unit_pkg::ST_ENTRY
        ##1 intTaken && intVector == flag_unit_pkg::VEC_TRAP)
        else $error("trap not taken");
    a_nmi_taken: assert property (nmiPend_reg && boundary
        |=> state_reg == flag_unit_pkg::ST_ENTRY)
        else $error("nonmaskable not taken");
    a_entry_pushes: assert property (state_reg
        == flag_unit_pkg::ST_ENTRY |=> !flags_reg[9]
        && sp_reg == $past(sp_reg) + 3'h1)
        else $error("entry push wrong");
    a_return_restores: assert property (returnIssue
        ##1 state_reg == flag_unit_pkg::ST_POP
        |=> flags_reg == $past(stackRd) && instrDone)
        else $error("return did not restore flags");
    a_rotate_carry_in: assert property (isExec
        && op_reg == flag_unit_pkg::OP_ROT_LEFT
        |=> operand_reg[0] == $past(flags_reg[0])
            && flags_reg[0] == $past(operand_reg[15]))
        else $error("rotate left carry wrong");
    a_eoi_clears: assert property (eoiWr
        && state_reg != flag_unit_pkg::ST_ENTRY |=> inService_reg == 4'h0)
        else $error("end of service did not clear");
    a_carry_clear_only: assert property (isExec
        && op_reg == flag_unit_pkg::OP_CLR_CARRY
        |=> !flags_reg[0] && flags_reg[15:1] == $past(flags_reg[15:1]))
        else $error("carry clear disturbed flags");

endmodule : flag_clear_instruction_unit

// ### sim/instr_source.sv
`timescale 1ns/1ps
// Instruction stream and request pins beside the core
module instr_source (
    input  wire logic       clk,
    input  wire logic       instrReady,
    input  wire logic       instrDone,
    output logic            instrValid,
    output logic      [7:0] instrOpcode,
    output logic      [3:0] irqPin,
    output logic            nmiPin
);
    // Quiet at time zero; nothing offered until commanded
    initial begin
        instrValid  = 1'b0;
        instrOpcode = 8'h00;
        irqPin      = 4'h0;
        nmiPin      = 1'b0;
    end

    // Offer one opcode, hold it until taken, then count edges to done
    task automatic issue(input logic [7:0] op, output int lat);
        lat = 0;
        instrValid  <= 1'b1;
        instrOpcode <= op;
        do @(posedge clk); while (instrReady !== 1'b1);
        instrValid  <= 1'b0;
        instrOpcode <= ~op; // Released bus must not look like a valid code
        do begin
            @(posedge clk);
            lat++;
        end while (instrDone !== 1'b1 && lat < 50);
    endtask : issue

    // Request levels; a maskable request only lives while its pin is held, a nonmaskable one is latched on its rising edge
    task automatic setPins(input logic [3:0] irq, input logic nmi);
        irqPin <= irq;
        nmiPin <= nmi;
    endtask : setPins
endmodule : instr_source

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        instrValid;
    logic [7:0]  instrOpcode;
    logic        instrReady;
    logic        instrDone;
    logic [3:0]  irqPin;
    logic        nmiPin;
    logic        intTaken;
    logic [2:0]  intVector;
    logic [15:0] flagsOut;
    logic [15:0] srcIndexOut;
    logic [15:0] dstIndexOut;
    int          errorCnt = 0;
    int          checks   = 0;
    int          takenCnt = 0;
    int          lat;
    int          n0;
    logic [31:0] rd;
    logic        err;

    typedef struct {
        logic [7:0]  op;
        logic [15:0] pre;
        logic [15:0] post;
    } row_s;
    // Opcode, flags before, flags expected after
    row_s rows [7] = '{
        '{flag_unit_pkg::OP_CLR_CARRY, 16'h0601, 16'h0600},
        '{flag_unit_pkg::OP_CLR_DIR,   16'h0601, 16'h0201},
        '{flag_unit_pkg::OP_CLR_IRQEN, 16'h0601, 16'h0401},
        '{flag_unit_pkg::OP_SET_CARRY, 16'h0000, 16'h0001},
        '{flag_unit_pkg::OP_SET_DIR,   16'h0000, 16'h0400},
        '{flag_unit_pkg::OP_SET_IRQEN, 16'h0000, 16'h0200},
        '{8'h00,                       16'h0601, 16'h0601}};

    flag_clear_instruction_unit i_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instrValid(instrValid),
        .instrOpcode(instrOpcode), .instrReady(instrReady),
        .instrDone(instrDone), .irqPin(irqPin), .nmiPin(nmiPin),
        .intTaken(intTaken), .intVector(intVector), .flagsOut(flagsOut),
        .srcIndexOut(srcIndexOut), .dstIndexOut(dstIndexOut));

    instr_source i_src (
        .clk(clk), .instrReady(instrReady), .instrDone(instrDone),
        .instrValid(instrValid), .instrOpcode(instrOpcode),
        .irqPin(irqPin), .nmiPin(nmiPin));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Entry pulses are one cycle long, so count them as they pass
    always @(posedge clk) if (intTaken === 1'b1) takenCnt++;

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Bounded wait for one handler entry, then its vector
    task automatic entry(input logic [2:0] vec);
        int k;
        k = 0;
        while (takenCnt == n0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk("intTaken", 32'h1, takenCnt - n0);
        chk("intVector", {29'h0, vec}, {29'h0, intVector});
        @(posedge clk);
    endtask : entry

    task automatic results();
        $display("checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // Watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        errorCnt++;
        results();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        apb(1'b0, flag_unit_pkg::OFF_FLAGS, 32'h0);
        chk("flags reset", 32'h0, rd);
        apb(1'b0, flag_unit_pkg::OFF_MASK, 32'h0);
        chk("mask reset", 32'hf, rd);
        apb(1'b1, 8'h40, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        foreach (rows[i]) begin
            apb(1'b1, flag_unit_pkg::OFF_FLAGS, {16'h0, rows[i].pre});
            i_src.issue(rows[i].op, lat);
            chk("latency", 32'h2, lat);
            chk("flags", {16'h0, rows[i].post}, {16'h0, flagsOut});
        end
        // Carry cleared right before a rotate must feed that rotate
        apb(1'b1, flag_unit_pkg::OFF_FLAGS, 32'h1);
        apb(1'b1, flag_unit_pkg::OFF_OPERAND, 32'h8001);
        i_src.issue(flag_unit_pkg::OP_CLR_CARRY, lat);
        i_src.issue(flag_unit_pkg::OP_ROT_LEFT, lat);
        apb(1'b0, flag_unit_pkg::OFF_OPERAND, 32'h0);
        chk("rotate left", 32'h0002, rd);
        chk("carry", 32'h1, {31'h0, flagsOut[0]});
        i_src.issue(flag_unit_pkg::OP_ROT_RIGHT, lat);
        apb(1'b0, flag_unit_pkg::OFF_OPERAND, 32'h0);
        chk("rotate right", 32'h8001, rd);
        // Two string steps upward
        apb(1'b1, flag_unit_pkg::OFF_SRC, 32'h0010);
        apb(1'b1, flag_unit_pkg::OFF_DST, 32'h0020);
        apb(1'b1, flag_unit_pkg::OFF_FLAGS, 32'h0);
        i_src.issue(flag_unit_pkg::OP_STRING, lat);
        i_src.issue(flag_unit_pkg::OP_STRING, lat);
        chk("src", 32'h0012, {16'h0, srcIndexOut});
        chk("dst", 32'h0022, {16'h0, dstIndexOut});
        // Direction set: the step still moves, now downward
        apb(1'b1, flag_unit_pkg::OFF_FLAGS, 32'h0400);
        i_src.issue(flag_unit_pkg::OP_STRING, lat);
        chk("src down", 32'h0011, {16'h0, srcIndexOut});
        chk("dst down", 32'h0021, {16'h0, dstIndexOut});
        // Maskable request held off by clear, then by the enable shadow
        apb(1'b1, flag_unit_pkg::OFF_MASK, 32'h0);
        apb(1'b1, flag_unit_pkg::OFF_FLAGS, 32'h0200);
        i_src.issue(flag_unit_pkg::OP_CLR_IRQEN, lat);
        n0 = takenCnt;
        i_src.setPins(4'h2, 1'b0);
        repeat (8) @(posedge clk);
        chk("held off", 32'h0, takenCnt - n0);
        i_src.issue(flag_unit_pkg::OP_SET_IRQEN, lat);
        repeat (6) @(posedge clk);
        chk("shadow", 32'h0, takenCnt - n0);
        i_src.issue(8'h00, lat);
        entry(3'h1);
        apb(1'b0, flag_unit_pkg::OFF_IN_SERVICE_BITS, 32'h0);
        chk("in service", 32'h2, rd);
        i_src.setPins(4'h0, 1'b0);
        i_src.issue(flag_unit_pkg::OP_SET_DIR, lat);
        i_src.issue(flag_unit_pkg::OP_RETURN, lat);
        chk("return latency", 32'h3, lat);
        chk("flags popped", 32'h0200, {16'h0, flagsOut});
        // Only the exact command code ends service
        apb(1'b1, flag_unit_pkg::OFF_EOI, 32'h1234);
        apb(1'b0, flag_unit_pkg::OFF_IN_SERVICE_BITS, 32'h0);
        chk("bad eoi", 32'h2, rd);
        apb(1'b1, flag_unit_pkg::OFF_EOI, 32'h8000);
        apb(1'b0, flag_unit_pkg::OFF_IN_SERVICE_BITS, 32'h0);
        chk("eoi", 32'h0, rd);
        // Trap and nonmaskable entries with enable off and all masked
        apb(1'b1, flag_unit_pkg::OFF_MASK, 32'hf);
        apb(1'b1, flag_unit_pkg::OFF_FLAGS, 32'h0);
        n0 = takenCnt;
        i_src.issue(flag_unit_pkg::OP_TRAP_CALL, lat);
        entry(flag_unit_pkg::VEC_TRAP);
        i_src.issue(flag_unit_pkg::OP_RETURN, lat);
        n0 = takenCnt;
        i_src.setPins(4'h0, 1'b1);
        entry(flag_unit_pkg::VEC_NMI);
        i_src.setPins(4'h0, 1'b0);
        i_src.issue(flag_unit_pkg::OP_RETURN, lat);
        chk("flags after nmi", 32'h0, {16'h0, flagsOut});
        // Mid-run reset; ready only shows one edge after release
        apb(1'b1, flag_unit_pkg::OFF_FLAGS, 32'h0601);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("flags after reset", 32'h0, {16'h0, flagsOut});
        chk("src after reset", 32'h0, {16'h0, srcIndexOut});
        chk("ready after reset", 32'h1, {31'h0, instrReady});
        apb(1'b0, flag_unit_pkg::OFF_MASK, 32'h0);
        chk("mask after reset", 32'hf, rd);
        results();
    end
endmodule : tb
